/* File: video_test_pattern_generator.sv */
`timescale 1ns/10ps
`include "tpg_defines.svh"

// ==========================================================
// Sample FIFO
module pix_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 32
) (
    input  wire logic                       clock,
    input  wire logic                       resetn,
    input  wire logic                       wr_valid,
    output logic                            wr_ready,
    input  wire logic [W-1:0]               wr_data,
    output logic                            rd_valid,
    input  wire logic                       rd_ready,
    output logic [W-1:0]                    rd_data,
    output logic [$clog2(DEPTH):0]          count
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // Flags come from the count, so full and empty never lie
    always_comb begin
        wr_ready = cnt_q != FULL;
        rd_valid = cnt_q != '0;
        rd_data  = mem[rp_q];
        count    = cnt_q;
        push     = wr_valid && wr_ready;
        pop      = rd_valid && rd_ready;
        wp_d     = push ? wp_q + 1'b1 : wp_q;
        rp_d     = pop ? rp_q + 1'b1 : rp_q;
        cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_q] <= wr_data;
        end
    end
endmodule

// ==========================================================
// Pattern generator
module video_test_pattern_generator import tpg_pkg::*; (
    input  wire logic     clock,
    input  wire logic     resetn,
    input  wire pat_sel_t pat,
    input  wire logic     fmt12,
    input  wire logic     ext_present,
    input  wire pos_t     pos,
    input  wire logic     pos_valid,
    output logic          pos_ready,
    output pix_t          pix,
    output logic          pix_valid,
    input  wire logic     pix_ready,
    output logic          sel_err
);
    // Scale a 10-bit level to the active format
    function automatic logic [11:0] sc(input logic [9:0] c, input logic f12);
        return f12 ? {c, 2'b00} : {2'b00, c};
    endfunction

    // floor(p * n / len), with rcp = 2^20 / len
    function automatic logic [11:0] frac(input logic [10:0] p, input logic [11:0] n,
                                         input logic [9:0] rcp);
        logic [35:0] m;
        m = 36'(p) * 36'(n) * 36'(rcp);
        return 12'(m >> 20);
    endfunction

    // Video level in twentieths of the luma span
    function automatic logic [9:0] lvl20(input logic [4:0] k);
        logic [31:0] m;
        m = 32'(`Y_SPAN) * 32'(k) * 32'h0000_0ccd;
        return 10'(`Y_LO + 10'(m >> 16));
    endfunction

    // Hue corners {r,g,b}: red yellow green cyan magenta blue red
    function automatic logic [2:0] hue(input logic [2:0] i);
        case (i)
            3'h0: return 3'b100;
            3'h1: return 3'b110;
            3'h2: return 3'b010;
            3'h3: return 3'b011;
            3'h4: return 3'b101;
            3'h5: return 3'b001;
            default: return 3'b100;
        endcase
    endfunction

    // Colour mask for arg 0..5: red green blue cyan magenta yellow
    function automatic logic [2:0] cmask(input logic [2:0] a);
        case (a)
            3'h0: return 3'b100;
            3'h1: return 3'b010;
            3'h2: return 3'b001;
            3'h3: return 3'b011;
            3'h4: return 3'b101;
            default: return 3'b110;
        endcase
    endfunction

    logic        take, bad, g_valid_q, g_valid_d, f_wr_ready, f_rd_valid, f_rd_ready;
    logic        pos_ready_d, pix_valid_d, sel_err_d;
    pix_t        a, g_pix_q, g_pix_d, pix_d, f_rd_data;
    logic [5:0]  f_count;
    logic [11:0] bar, seg, r, lo, lim_lo, lim_hi, span, sh_row;
    logic [10:0] body;
    logic [9:0]  ys, cs, hv, lv;
    logic [2:0]  row, cseg, sat, val, ha, hb, m;
    logic [7:0]  t, ch, x, y;
    logic [9:0]  cm [3];

    // Selection check; extended patterns black out when the set is absent
    always_comb begin
        case (pat.kind)
            pk_flat:     bad = pat.arg > 4'ha || (!ext_present && pat.arg != 4'h0
                               && pat.arg != 4'h5 && pat.arg != 4'ha);
            pk_field100: bad = pat.arg > 4'h5;
            pk_field75:  bad = pat.arg > 4'h5 || !ext_present;
            pk_stepw,
            pk_stepg:    bad = pat.arg == 4'h0 || pat.arg > 4'ha || !ext_present;
            pk_accur:    bad = pat.arg[2:0] > 3'h5 || !ext_present;
            default:     bad = pat.kind > pk_accur;
        endcase
    end

    // Pixel code from position and pattern; one per accepted position
    always_comb begin
        a      = '0;
        lo     = sc(`Y_LO, fmt12);
        lim_lo = fmt12 ? `LIM_LO12 : `LIM_LO10;
        lim_hi = fmt12 ? `LIM_HI12 : `LIM_HI10;
        seg    = frac(pos.h, 12'h010, `RCP_BAR);
        bar    = frac(pos.h, pat.kind == pk_stair10 ? 12'h00b : 12'h006, `RCP_BAR);
        ys     = 10'(`ST_BASE + 10'(bar) * (pat.kind == pk_stair10 ? `ST_Y10 : `ST_Y5));
        cs     = 10'(`ST_BASE + 10'(bar) * (pat.kind == pk_stair10 ? `ST_C10 : `ST_C5));
        r      = frac(pos.h, `Y_SPAN, `RCP_W);
        r      = r > `Y_SPAN ? `Y_SPAN : r;
        body   = 11'(pos.h - 11'(`SEG_W * 11'h002));
        span   = `Y_SPAN;
        sh_row = frac(pos.v, 12'h00a, `RCP_H);
        row    = 3'(frac(pos.v, 12'h008, `RCP_H));
        cseg   = 3'(frac(pos.h, 12'h006, `RCP_BAR));
        t      = 8'((12'(11'(pos.h - 11'(cseg) * `CM_SEG_W)) * 12'h333) >> 10);
        ha     = hue(cseg);
        hb     = hue(3'(cseg + 3'h1));
        sat    = row < 3'h3 ? 3'(row + 3'h1) : 3'h4;
        val    = row > 3'h3 ? 3'(3'h7 - row) : 3'h4;
        hv     = lvl20(5'h14);
        lv     = lvl20(5'h0f);
        m      = cmask(pat.arg[2:0]);
        for (int i = 0; i < 3; i++) begin
            // Linear blend between neighbouring hues, then saturation and value
            ch = ha[2-i] ? (hb[2-i] ? 8'hff : ~t) : (hb[2-i] ? t : 8'h00);
            x = 8'hff - 8'((10'(sat) * 10'(8'hff - ch)) >> 2);
            y = 8'((10'(x) * 10'(val)) >> 2);
            if (row == 3'h7) begin
                y = frac(pos.h, 12'h100, `RCP_W) > 12'h0ff ? 8'hff
                    : 8'(frac(pos.h, 12'h100, `RCP_W));
            end
            // Top of scale maps to 936, so every colour stays in gamut
            cm[i] = 10'(`Y_LO + 10'((18'(y) * 18'(`Y_SPAN)) >> 8));
        end
        case (pat.kind)
            pk_stair5, pk_stair10: begin
                a.c0 = sc(ys, fmt12);
                a.c1 = sc(cs, fmt12);
                a.c2 = sc(cs, fmt12);
            end
            pk_vramp, pk_yramp, pk_cbramp, pk_crramp: begin
                // Matrix takes the ramp from the row third; singles span the width
                a.c0 = sc(`MID_Y, fmt12);
                a.c1 = sc(`MID_C, fmt12);
                a.c2 = sc(`MID_C, fmt12);
                r    = frac(pos.h, `C_SPAN, `RCP_W);
                r    = r > `C_SPAN ? `C_SPAN : r;
                case (pat.kind == pk_vramp ? 2'(frac(pos.v, 12'h003, `RCP_H)) :
                      2'(pat.kind - pk_yramp))
                    2'h0: a.c0 = sc(10'(`Y_LO + 10'(frac(pos.h, `Y_SPAN, `RCP_W) > `Y_SPAN ?
                                `Y_SPAN : frac(pos.h, `Y_SPAN, `RCP_W))), fmt12);
                    2'h1: a.c1 = sc(10'(`Y_LO + 10'(r)), fmt12);
                    default: a.c2 = sc(10'(`Y_LO + 10'(r)), fmt12);
                endcase
            end
            pk_ramp3: begin
                // Blank, ramp from valid low, valid high, blank
                r = frac(body, `Y_SPAN, `RCP_R);
                r = r > `Y_SPAN ? `Y_SPAN : r;
                a.c0 = seg < 12'h002 ? lo : seg > 12'h00d ?
                       (seg == 12'h00f ? lo : sc(`Y_HI, fmt12)) :
                       sc(10'(`Y_LO + 10'(r)), fmt12);
                a.c1 = a.c0;
                a.c2 = a.c0;
            end
            pk_limit: begin
                body = 11'(pos.h - 11'(`SEG_W * 11'h003));
                span = lim_hi - lim_lo;
                r = frac(body, span, `RCP_L);
                r = r > span ? span : r;
                case (seg)
                    12'h000, 12'h001, 12'h00f: a.c0 = lo;
                    12'h002: a.c0 = lim_lo;
                    12'h00d: a.c0 = lim_hi;
                    12'h00e: a.c0 = sc(`Y_HI, fmt12);
                    default: a.c0 = lim_lo + r;
                endcase
                a.c1 = a.c0;
                a.c2 = a.c0;
            end
            pk_shallow: begin
                // Each row starts short of the last row's end, so rows overlap
                r = lim_lo + 12'(sh_row * (fmt12 ? `SH_STEP12 : `SH_STEP10))
                    + 12'(fmt12 ? pos.h >> 2 : pos.h >> 4);
                a.c0 = r > lim_hi ? lim_hi : r;
                a.c1 = a.c0;
                a.c2 = a.c0;
            end
            pk_cmatrix: begin
                a.c0 = sc(cm[0], fmt12);
                a.c1 = sc(cm[1], fmt12);
                a.c2 = sc(cm[2], fmt12);
            end
            pk_flat, pk_stepw, pk_stepg: begin
                a.c0 = sc(lvl20(pat.kind == pk_stepg ? 5'(pat.arg) : 5'({pat.arg, 1'b0})),
                          fmt12);
                a.c1 = a.c0;
                a.c2 = a.c0;
            end
            pk_field100, pk_field75, pk_accur: begin
                // Accuracy level 2 lifts the off channels to half value
                a.c0 = sc(m[2] ? (pat.kind == pk_field75 ? lv : hv) :
                          (pat.kind == pk_accur && pat.arg[3] ? lvl20(5'h0a) : `Y_LO),
                          fmt12);
                a.c1 = sc(m[1] ? (pat.kind == pk_field75 ? lv : hv) :
                          (pat.kind == pk_accur && pat.arg[3] ? lvl20(5'h0a) : `Y_LO), fmt12);
                a.c2 = sc(m[0] ? (pat.kind == pk_field75 ? lv : hv) :
                          (pat.kind == pk_accur && pat.arg[3] ? lvl20(5'h0a) : `Y_LO), fmt12);
            end
            default: a = '0;
        endcase
        if (bad) begin
            a = '{c0: lo, c1: lo, c2: lo};
        end
    end

    // Handshake: ready leaves room in the FIFO for the sample in flight
    always_comb begin
        take        = pos_valid && pos_ready;
        g_valid_d   = take || (g_valid_q && !f_wr_ready);
        g_pix_d     = take ? a : g_pix_q;
        pos_ready_d = f_count <= `READY_ROOM;
        f_rd_ready  = !pix_valid || pix_ready;
        pix_valid_d = f_rd_valid || (pix_valid && !pix_ready);
        pix_d       = (f_rd_valid && f_rd_ready) ? f_rd_data : pix;
        sel_err_d   = bad;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            g_valid_q <= 1'b0;
            g_pix_q   <= '0;
            pos_ready <= 1'b0;
            pix_valid <= 1'b0;
            pix       <= '0;
            sel_err   <= 1'b0;
        end else begin
            g_valid_q <= g_valid_d;
            g_pix_q   <= g_pix_d;
            pos_ready <= pos_ready_d;
            pix_valid <= pix_valid_d;
            pix       <= pix_d;
            sel_err   <= sel_err_d;
        end
    end

    pix_fifo #(.W(36), .DEPTH(32)) u_fifo (
        .clock    (clock),
        .resetn   (resetn),
        .wr_valid (g_valid_q),
        .wr_ready (f_wr_ready),
        .wr_data  (g_pix_q),
        .rd_valid (f_rd_valid),
        .rd_ready (f_rd_ready),
        .rd_data  (f_rd_data),
        .count    (f_count)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    stair_first_a: assert property (take && pat.kind == pk_stair5 && pos.h == 11'h000
        && !fmt12 |=> g_pix_q.c0 == 12'h03e && g_pix_q.c1 == 12'h03e)
        else $error("staircase first bar not at 62");
    stair_last_a: assert property (take && pat.kind == pk_stair10 && pos.h == 11'h77f
        && !fmt12 |=> g_pix_q.c0 == 12'h3ae && g_pix_q.c1 == 12'h3c2)
        else $error("staircase last bar wrong");
    stair_chan_a: assert property (take && (pat.kind == pk_stair5 || pat.kind == pk_stair10)
        |=> g_pix_q.c1 == g_pix_q.c2)
        else $error("staircase channels differ");
    yramp_valid_a: assert property (take && pat.kind == pk_yramp && !fmt12
        |=> g_pix_q.c0 >= 12'h040 && g_pix_q.c0 <= 12'h3ac && g_pix_q.c1 == 12'h200)
        else $error("luma ramp outside valid range");
    limit_span_a: assert property (take && pat.kind == pk_limit && fmt12
        |=> g_pix_q.c0 >= 12'h010 && g_pix_q.c0 <= 12'hfef && g_pix_q.c1 == g_pix_q.c2)
        else $error("limit ramp outside limits");
    shallow_step_a: assert property (take && pat.kind == pk_shallow && !fmt12
        && pos.v == 11'h000 && pos.h == 11'h01f |=> g_pix_q.c0 == 12'h005)
        else $error("shallow ramp hold length wrong");
    flat_white_a: assert property (take && pat.kind == pk_flat && pat.arg == 4'ha
        && !fmt12 |=> g_pix_q.c0 == 12'h3ac && g_pix_q.c2 == 12'h3ac)
        else $error("white field wrong");
    red_field_a: assert property (take && pat.kind == pk_field100 && pat.arg == 4'h0
        && !fmt12 |=> g_pix_q.c0 == 12'h3ac && g_pix_q.c1 == 12'h040)
        else $error("red field wrong");
    ext_gate_a: assert property (take && pat.kind == pk_field75 && !ext_present
        && !fmt12 |=> sel_err && g_pix_q.c0 == 12'h040)
        else $error("extended field passed without set");
    out_hold_a: assert property (pix_valid && !pix_ready
        |=> pix_valid && $stable(pix))
        else $error("output changed under back-pressure");
    no_drop_a: assert property (g_valid_q && !f_wr_ready |-> !take)
        else $error("generated sample overwritten");

    stair_cov: cover property (take && pat.kind == pk_stair10);
    matrix_cov: cover property (take && pat.kind == pk_cmatrix && pos.v == 11'h437);
    full_cov: cover property (f_count == 6'h20);
    stall_cov: cover property (pix_valid && !pix_ready ##1 pix_ready);
endmodule

/* File: tpg_defines.svh */
`ifndef TPG_DEFINES_SVH
`define TPG_DEFINES_SVH

// ==========================================================
// Levels in 10-bit units (12-bit formats use four times these)
`define Y_LO      10'h040
`define Y_HI      10'h3ac
`define C_HI      10'h3c0
`define MID_Y     10'h1f6
`define MID_C     10'h200
`define ST_BASE   10'h03e
`define ST_Y5     10'h0b0
`define ST_C5     10'h0b4
`define ST_Y10    10'h058
`define ST_C10    10'h05a
`define Y_SPAN    12'h36c
`define C_SPAN    12'h380

// ==========================================================
// Legal limit codes and shallow ramp row steps, per format
`define LIM_LO10  12'h004
`define LIM_HI10  12'h3fb
`define LIM_LO12  12'h010
`define LIM_HI12  12'hfef
`define SH_STEP10 12'h066
`define SH_STEP12 12'h1c3

// ==========================================================
// Raster geometry, reciprocals scaled by 2^20, and the FIFO count for pos_ready
`define RCP_BAR   10'h222
`define RCP_W     10'h223
`define RCP_R     10'h2d9
`define RCP_L     10'h36b
`define RCP_H     10'h3cb
`define SEG_W     11'h078
`define CM_SEG_W  11'h140
`define READY_ROOM 6'h1c

`endif

/* File: tpg_pkg.sv */
package tpg_pkg;

    // ==========================================================
    // Pattern kinds; arg picks level, colour or step
    typedef enum logic [4:0] {
        pk_stair5, pk_stair10, pk_vramp, pk_yramp, pk_cbramp, pk_crramp,
        pk_ramp3, pk_limit, pk_shallow, pk_cmatrix, pk_flat, pk_field100,
        pk_field75, pk_stepw, pk_stepg, pk_accur
    } kind_t;

    typedef struct packed {
        kind_t      kind;
        logic [3:0] arg;
    } pat_sel_t;

    // Active raster position
    typedef struct packed {
        logic [10:0] h;
        logic [10:0] v;
    } pos_t;

    // One sample per channel, codes right aligned
    typedef struct packed {
        logic [11:0] c0;
        logic [11:0] c1;
        logic [11:0] c2;
    } pix_t;

endpackage

/* File: pix_sink.sv */
`timescale 1ns/10ps

// ==========================================================
// Sample sink standing in for the output formatter
module pix_sink import tpg_pkg::*; (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic stall,
    input  wire pix_t pix,
    input  wire logic pix_valid,
    output logic      pix_ready
);
    pix_t got_q[$];

    initial pix_ready = 1'b0;

    // Ready moves just after the edge; stall builds back-pressure for the FIFO
    always @(posedge clock) begin
        if (resetn === 1'b1 && pix_valid === 1'b1 && pix_ready === 1'b1) begin
            got_q.push_back(pix);
        end
        pix_ready <= #2 (resetn === 1'b1) && !stall;
    end
endmodule

/* File: test_video_test_pattern_generator.sv */
`timescale 1ns/10ps

// ==========================================================
// Bench for the pattern generator
module test_video_test_pattern_generator import tpg_pkg::*;;
    logic     clock;
    logic     resetn;
    logic     fmt12;
    logic     ext_present;
    logic     pos_valid;
    logic     pos_ready;
    logic     pix_valid;
    logic     pix_ready;
    logic     sel_err;
    logic     stall;
    pat_sel_t pat;
    pos_t     pos;
    pix_t     pix;
    int       n_mismatch;
    int       comparisons;

    video_test_pattern_generator video_test_pattern_generator_inst (
        .clock(clock), .resetn(resetn), .pat(pat), .fmt12(fmt12), .ext_present(ext_present),
        .pos(pos), .pos_valid(pos_valid), .pos_ready(pos_ready), .pix(pix),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .sel_err(sel_err));

    pix_sink pix_sink_inst (
        .clock(clock), .resetn(resetn), .stall(stall), .pix(pix),
        .pix_valid(pix_valid), .pix_ready(pix_ready));

    // 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ==========================================================
    // Shared helpers
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // A wait that runs out is a failure in its own right
    task automatic timeout(input string what);
        n_mismatch++;
        $display("wrong value %s expected handshake seen none", what);
        final_report();
    endtask

    // Codes are given in 10-bit units and scaled for the 12-bit format
    function automatic logic [11:0] s(input logic [11:0] c);
        return (fmt12 === 1'b1) ? {c[9:0], 2'b00} : c;
    endfunction

    // Offer one position; held until an edge sees pos_ready high
    task automatic run(input kind_t k, input logic [3:0] a, input logic [10:0] h,
                       input logic [10:0] v, input logic [11:0] e0, input logic [11:0] e1,
                       input logic [11:0] e2, input logic err);
        logic ok;
        int   n;
        pix_t p;
        pat       = '{kind: k, arg: a};
        pos       = '{h: h, v: v};
        pos_valid = 1'b1;
        ok        = 1'b0;
        for (n = 0; n < 50 && ok !== 1'b1; n++) begin
            ok = pos_ready;
            @(posedge clock);
            #2;
        end
        pos_valid = 1'b0;
        if (ok !== 1'b1) timeout("pos_ready");
        for (n = 0; n < 20 && pix_sink_inst.got_q.size() == 0; n++) begin
            @(posedge clock);
            #2;
        end
        if (n == 20) timeout("pix_valid");
        p = pix_sink_inst.got_q.pop_front();
        check("c0", e0, p.c0);
        check("c1", e1, p.c1);
        check("c2", e2, p.c2);
        check("sel_err", {11'h000, err}, {11'h000, sel_err});
    endtask

    task automatic run3(input kind_t k, input logic [3:0] a, input logic [10:0] h,
                        input logic [10:0] v, input logic [11:0] e, input logic err);
        run(k, a, h, v, e, e, e, err);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_stair();
        for (int i = 0; i < 2; i++) begin
            fmt12 = i[0];
            run3(pk_stair5, 4'h0, 11'h000, 11'h000, s(12'h03e), 1'b0);
            run(pk_stair5, 4'h0, 11'h77f, 11'h000, s(12'h3ae), s(12'h3c2), s(12'h3c2), 1'b0);
            run(pk_stair5, 4'h0, 11'h190, 11'h000, s(12'h0ee), s(12'h0f2), s(12'h0f2), 1'b0);
            run(pk_stair10, 4'h0, 11'h0c8, 11'h000, s(12'h096), s(12'h098), s(12'h098), 1'b0);
        end
        $display("test stair done");
    endtask

    task automatic test_ramps();
        for (int i = 0; i < 2; i++) begin
            fmt12 = i[0];
            run(pk_yramp, 4'h0, 11'h000, 11'h000, s(12'h040), s(12'h200), s(12'h200), 1'b0);
            run(pk_crramp, 4'h0, 11'h000, 11'h000, s(12'h1f6), s(12'h200), s(12'h040), 1'b0);
            run(pk_cbramp, 4'h0, 11'h000, 11'h000, s(12'h1f6), s(12'h040), s(12'h200), 1'b0);
            run(pk_vramp, 4'h0, 11'h000, 11'h000, s(12'h040), s(12'h200), s(12'h200), 1'b0);
            run3(pk_ramp3, 4'h0, 11'h000, 11'h000, s(12'h040), 1'b0);
            run3(pk_ramp3, 4'h0, 11'h6a4, 11'h000, s(12'h3ac), 1'b0);
            run3(pk_limit, 4'h0, 11'h12c, 11'h000, i[0] ? 12'h010 : 12'h004, 1'b0);
            run3(pk_limit, 4'h0, 11'h640, 11'h000, i[0] ? 12'hfef : 12'h3fb, 1'b0);
            run3(pk_shallow, 4'h0, i[0] ? 11'h003 : 11'h00f, 11'h000, s(12'h004), 1'b0);
            run3(pk_shallow, 4'h0, i[0] ? 11'h004 : 11'h010, 11'h000,
                 i[0] ? 12'h011 : 12'h005, 1'b0);
        end
        $display("test ramps done");
    endtask

    // Colour table: bit 2 red, bit 1 green, bit 0 blue for colours 0..5
    task automatic test_flat();
        logic [2:0] rgb [6] = '{3'b100, 3'b010, 3'b001, 3'b011, 3'b101, 3'b110};
        fmt12 = 1'b0;
        run3(pk_flat, 4'h0, 11'h000, 11'h000, 12'h040, 1'b0);
        run3(pk_flat, 4'h5, 11'h3c0, 11'h21c, 12'h1f6, 1'b0);
        run3(pk_flat, 4'ha, 11'h77f, 11'h437, 12'h3ac, 1'b0);
        for (int c = 0; c < 6; c++) begin
            run(pk_field100, 4'(c), 11'h100, 11'h100, rgb[c][2] ? 12'h3ac : 12'h040,
                rgb[c][1] ? 12'h3ac : 12'h040, rgb[c][0] ? 12'h3ac : 12'h040, 1'b0);
        end
        $display("test flat done");
    endtask

    // Colour matrix: top row is desaturated, the fourth row (row 3) fully saturated, bottom row grey
    task automatic test_matrix();
        fmt12 = 1'b0;
        run(pk_cmatrix, 4'h0, 11'h000, 11'h000, 12'h3a8, 12'h2d1, 12'h2d1, 1'b0);
        run(pk_cmatrix, 4'h0, 11'h000, 11'h1c2, 12'h3a8, 12'h040, 12'h040, 1'b0);
        run3(pk_cmatrix, 4'h0, 11'h000, 11'h437, 12'h040, 1'b0);
        run3(pk_cmatrix, 4'h0, 11'h77f, 11'h437, 12'h3a8, 1'b0);
        $display("test matrix done");
    endtask

    task automatic test_ext();
        fmt12       = 1'b0;
        ext_present = 1'b0;
        run3(pk_flat, 4'h1, 11'h000, 11'h000, 12'h040, 1'b1);
        run3(pk_field75, 4'h0, 11'h000, 11'h000, 12'h040, 1'b1);
        run3(pk_stepw, 4'ha, 11'h000, 11'h000, 12'h040, 1'b1);
        run3(pk_stepg, 4'h3, 11'h000, 11'h000, 12'h040, 1'b1);
        run3(pk_accur, 4'h0, 11'h000, 11'h000, 12'h040, 1'b1);
        ext_present = 1'b1;
        run(pk_field75, 4'h0, 11'h000, 11'h000, 12'h2d1, 12'h040, 12'h040, 1'b0);
        run3(pk_stepw, 4'ha, 11'h000, 11'h000, 12'h3ac, 1'b0);
        run3(pk_stepg, 4'ha, 11'h000, 11'h000, 12'h1f6, 1'b0);
        run(pk_accur, 4'h0, 11'h000, 11'h000, 12'h3ac, 12'h040, 12'h040, 1'b0);
        ext_present = 1'b0;
        $display("test ext done");
    endtask

    // Back-to-back takes into a stalled sink, then a drain checked in order
    task automatic test_stall();
        logic [11:0] e0[$];
        logic [11:0] e1[$];
        logic        ok;
        int          n;
        pix_t        p;
        pat       = '{kind: pk_stair10, arg: 4'h0};
        pos       = '{h: 11'h050, v: 11'h000};
        stall     = 1'b1;
        pos_valid = 1'b1;
        for (n = 0; n < 60; n++) begin
            ok = pos_ready;
            @(posedge clock);
            #2;
            if (ok === 1'b1) begin
                e0.push_back(12'(62 + 88 * (e0.size() % 11)));
                e1.push_back(12'(62 + 90 * (e1.size() % 11)));
                pos.h = 11'((e0.size() % 11) * 175 + 80);
            end
        end
        pos_valid = 1'b0;
        check("pos_ready", 12'h000, {11'h000, pos_ready});
        check("taken", 12'h001, {11'h000, e0.size() >= 29});
        check("pix_valid", 12'h001, {11'h000, pix_valid});
        stall = 1'b0;
        for (n = 0; n < 100 && pix_sink_inst.got_q.size() < e0.size(); n++) begin
            @(posedge clock);
            #2;
        end
        if (n == 100) timeout("drain");
        while (e0.size() > 0) begin
            p = pix_sink_inst.got_q.pop_front();
            check("c0", e0.pop_front(), p.c0);
            check("c2", e1.pop_front(), p.c2);
        end
        check("pix_valid", 12'h000, {11'h000, pix_valid});
        $display("test stall done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        resetn      = 1'b0;
        pos_valid   = 1'b0;
        stall       = 1'b0;
        fmt12       = 1'b0;
        ext_present = 1'b0;
        pat         = '{kind: pk_flat, arg: 4'h0};
        pos         = '0;
        n_mismatch  = 0;
        comparisons = 0;
        repeat (2) @(posedge clock);
        #2;
        check("pos_ready", 12'h000, {11'h000, pos_ready});
        check("pix_valid", 12'h000, {11'h000, pix_valid});
        check("sel_err", 12'h000, {11'h000, sel_err});
        resetn = 1'b1;
        @(posedge clock);
        #2;
        $display("test reset done");
        test_stair();
        test_ramps();
        test_flat();
        test_matrix();
        test_ext();
        test_stall();
        final_report();
    end
endmodule
